// ### design/dwt_pkg.sv
// Package for the two-channel converter control block: register map, fields, types
package dwt_pkg;
    localparam int NUM_CH = 2;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int CODE_W = 10;
    localparam int NUM_TIMERS = 6;
    localparam int CH_SEL_BIT = 12;
    localparam int PHASE_W = 11;
    localparam int HOLD_CNT_W = 6;

    // Register offsets within one channel block
    localparam logic [7:0] OFS_CONV_CONTROL = 8'h00;
    localparam logic [7:0] OFS_CONV_DATA = 8'h04;
    localparam logic [7:0] OFS_WAVE_CONTROL = 8'h08;
    localparam logic [7:0] OFS_WAVE_TRIGGER_COMMAND = 8'h0c;
    localparam logic [7:0] OFS_HOLD_TIME_ADJUST = 8'h10;

    // Field positions
    localparam int CTRL_DRIVE_BIT = 0;
    localparam int CTRL_REF_BIT = 1;
    localparam int DATA_CODE_LSB = 6;
    localparam int WAVE_MODE_LSB = 0;
    localparam int WAVE_DMA_BIT = 7;
    localparam int WAVE_TEN_BIT = 8;
    localparam int WAVE_TSEL_LSB = 9;
    localparam int WAVE_AMP_LSB = 16;
    localparam int WAVE_OFFSET_LSB = 18;
    localparam int TRIG_SW_BIT = 0;
    localparam int TRIG_CLEAR_BIT = 15;
    localparam int HOLD_PRE_LSB = 0;
    localparam int HOLD_POST_LSB = 4;

    // Reset values
    localparam logic [3:0] HOLD_POST_RST = 4'h8;
    localparam logic [3:0] HOLD_PRE_RST = 4'h1;
    localparam logic [9:0] LFSR_SEED = 10'h001;

    // Waveform arithmetic
    localparam logic [9:0] CODE_MAX = 10'h3ff;
    localparam logic [10:0] SINE_MID = 11'h200;
    localparam logic [2:0] OFFSET_RESERVED = 3'h7;
    localparam logic [2:0] OFFSET_MAX = 3'h6;

    // Output hold strobe: clock cycles per unit of the adjust fields
    localparam logic [2:0] HOLD_UNIT_CYCLES = 3'h2;

    typedef enum logic [1:0] {
        WAVE_NONE = 2'h0,
        WAVE_TRIANGLE = 2'h1,
        WAVE_NOISE = 2'h2,
        WAVE_SINE = 2'h3
    } dwt_wave_mode_t;

    typedef enum logic [1:0] {
        AMP_FULL = 2'h0,
        AMP_HALF = 2'h1,
        AMP_QUARTER = 2'h2,
        AMP_RESERVED = 2'h3
    } dwt_amp_t;

    localparam logic [2:0] TSEL_SOFTWARE = 3'h0;
    localparam logic [2:0] TSEL_EXTERNAL = 3'h1;
    localparam logic [2:0] TSEL_TIMER_BASE = 3'h2;

    typedef struct packed {
        logic [2:0] offset;
        dwt_amp_t amplitude_select;
        logic [2:0] trigger_source_select;
        logic trigger_function_enable;
        logic dma_request_enable;
        dwt_wave_mode_t mode;
    } dwt_wave_cfg_t;

    typedef struct packed {
        logic analog_drive_enable;
        logic reference_connect;
        logic output_hold_strobe;
        logic [CODE_W-1:0] code;
    } dwt_analog_t;
endpackage

// ### design/dwt_top.sv
// Two-channel converter control: registers, trigger gating, waveform generator, hold strobe
//
// Operation
// - Two independent channels, each with own register block and 10-bit code.
// - Control bit 1 connects the high reference; cleared at reset.
// - Control bit 0 drives the output; cleared means stopped, high impedance.
// - Data register holds the 10-bit code in bits 15-6; rest reads zero.
// - Analog output changes only on a trigger event or a clear command.
// - Wave bits 20-18 pick offset in eighths; 111 reserved.
// - Wave bits 17-16 pick amplitude full, half, quarter; 11 reserved.
// - Wave bits 11-9 pick software, external pin or six timer events.
// - Wave bit 8 enables the trigger function.
// - Wave bit 7 lets DMA write the code, interlocked to triggers.
// - Wave bits 1-0 select none, triangle, noise or sine.
// - Writing one to command bit 15 clears output and generator.
// - Command bit 0 fires one software trigger, only while triggers are enabled with the software source selected.
// - Hold bits 7-4 are the post adjust, reset 1000, never zero.
// - Hold bits 3-0 are the pre adjust, reset 0001, never zero.
// - With generation on, each trigger makes one table step and update.
// - Sine and triangle span offset eighths up to offset plus amplitude.
// - Sine period is 2048 steps.
// - Triangle step count depends on amplitude.
// - Triangle period is 2046, 1022 or 510 steps by amplitude.
// - Noise is white with a 1023 step period.
//
// Design decisions made here: the strobed register port and the register addresses.
module dwt_top (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [dwt_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [dwt_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [dwt_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic [dwt_pkg::NUM_CH-1:0] DMA_WR,
    input wire logic [dwt_pkg::DATA_W-1:0] DMA_WDATA,
    output logic [dwt_pkg::NUM_CH-1:0] DMA_REQ,
    input wire logic EXT_TRIG,
    input wire logic [dwt_pkg::NUM_TIMERS-1:0] TIMER_MATCH,
    output dwt_pkg::dwt_analog_t [dwt_pkg::NUM_CH-1:0] ANALOG
);
    import dwt_pkg::*;

    // Register state per channel
    logic ctrl_drive_r [NUM_CH];
    logic ctrl_ref_r [NUM_CH];
    logic [CODE_W-1:0] code_r [NUM_CH];
    dwt_wave_cfg_t wave_r [NUM_CH];
    logic [3:0] hold_post_r [NUM_CH];
    logic [3:0] hold_pre_r [NUM_CH];

    // Generator and output state
    logic [CODE_W-1:0] out_code_r [NUM_CH];
    logic [PHASE_W-1:0] phase_r [NUM_CH];
    logic [CODE_W-1:0] tri_r [NUM_CH];
    logic tri_down_r [NUM_CH];
    logic [CODE_W-1:0] lfsr_r [NUM_CH];
    logic [HOLD_CNT_W-1:0] hold_cnt_r [NUM_CH];
    logic [HOLD_CNT_W-1:0] hold_cnt_nxt [NUM_CH];
    logic strobe_r [NUM_CH];
    logic [NUM_CH-1:0] dma_req_r;
    logic [DATA_W-1:0] rdata_r;

    // Trigger inputs
    logic ext_meta_r;
    logic ext_sync_r;
    logic ext_prev_r;
    logic [NUM_TIMERS-1:0] timer_prev_r;
    logic ext_rise;
    logic [NUM_TIMERS-1:0] timer_rise;

    // Decode
    logic addr_ok;
    logic [7:0] reg_ofs;
    logic [NUM_CH-1:0] ch_hit;
    logic [NUM_CH-1:0] wr_ctrl;
    logic [NUM_CH-1:0] wr_data;
    logic [NUM_CH-1:0] wr_wave;
    logic [NUM_CH-1:0] wr_hold;
    logic [NUM_CH-1:0] clr_cmd;
    logic [NUM_CH-1:0] sw_pulse;
    logic [NUM_CH-1:0] trig_hit;
    logic [CODE_W-1:0] gen_code [NUM_CH];
    logic [CODE_W-1:0] tri_top [NUM_CH];

    function automatic logic [1:0] dwt_amp_shift(input dwt_amp_t amp);
        case (amp)
            AMP_FULL: dwt_amp_shift = 2'h0;
            AMP_HALF: dwt_amp_shift = 2'h1;
            default: dwt_amp_shift = 2'h2;
        endcase
    endfunction

    // Parabolic half-wave approximation, 2048-point phase
    function automatic logic [CODE_W-1:0] dwt_sine(input logic [PHASE_W-1:0] ph);
        logic [9:0] h;
        logic [19:0] prod;
        logic [10:0] half;
        logic [10:0] val;
        h = ph[9:0];
        prod = h * (10'h3ff - h);
        half = {2'h0, prod[17:9]};
        val = ph[10] ? (SINE_MID - half) : (SINE_MID + half);
        dwt_sine = val[CODE_W-1:0];
    endfunction

    // Lifts a span value by the offset in eighths of full scale, clamped to full scale
    function automatic logic [CODE_W-1:0] dwt_place(input logic [CODE_W-1:0] span, input logic [2:0] ofs);
        logic [2:0] o;
        logic [11:0] sum;
        o = (ofs == OFFSET_RESERVED) ? OFFSET_MAX : ofs;
        sum = {2'h0, span} + {2'h0, o, 7'h00};
        dwt_place = (sum > {2'h0, CODE_MAX}) ? CODE_MAX : sum[CODE_W-1:0];
    endfunction

    assign addr_ok = (REG_ADDR[ADDR_W-1:CH_SEL_BIT+1] == '0) && (REG_ADDR[CH_SEL_BIT-1:8] == '0);
    assign reg_ofs = REG_ADDR[7:0];
    assign ext_rise = ext_sync_r & ~ext_prev_r;
    assign timer_rise = TIMER_MATCH & ~timer_prev_r;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            logic [1:0] sh;
            logic [2:0] tidx;
            logic src;
            src = 1'b0;
            sh = dwt_amp_shift(wave_r[c].amplitude_select);
            tidx = wave_r[c].trigger_source_select - TSEL_TIMER_BASE;
            ch_hit[c] = addr_ok && (REG_ADDR[CH_SEL_BIT] == 1'(c));
            wr_ctrl[c] = REG_WR && ch_hit[c] && (reg_ofs == OFS_CONV_CONTROL);
            wr_data[c] = REG_WR && ch_hit[c] && (reg_ofs == OFS_CONV_DATA);
            wr_wave[c] = REG_WR && ch_hit[c] && (reg_ofs == OFS_WAVE_CONTROL);
            wr_hold[c] = REG_WR && ch_hit[c] && (reg_ofs == OFS_HOLD_TIME_ADJUST);
            clr_cmd[c] = REG_WR && ch_hit[c] && (reg_ofs == OFS_WAVE_TRIGGER_COMMAND)
                && REG_WDATA[TRIG_CLEAR_BIT];
            sw_pulse[c] = REG_WR && ch_hit[c] && (reg_ofs == OFS_WAVE_TRIGGER_COMMAND)
                && REG_WDATA[TRIG_SW_BIT] && wave_r[c].trigger_function_enable
                && (wave_r[c].trigger_source_select == TSEL_SOFTWARE);
            if (wave_r[c].trigger_source_select == TSEL_SOFTWARE) begin
                src = sw_pulse[c];
            end else if (wave_r[c].trigger_source_select == TSEL_EXTERNAL) begin
                src = ext_rise;
            end else begin
                src = timer_rise[tidx];
            end
            trig_hit[c] = wave_r[c].trigger_function_enable && src && !clr_cmd[c];
            tri_top[c] = CODE_MAX >> sh;
            case (wave_r[c].mode)
                WAVE_TRIANGLE: gen_code[c] = dwt_place(tri_r[c], wave_r[c].offset);
                WAVE_SINE: gen_code[c] = dwt_place(dwt_sine(phase_r[c]) >> sh, wave_r[c].offset);
                WAVE_NOISE: gen_code[c] = lfsr_r[c];
                default: gen_code[c] = code_r[c];
            endcase
            if (trig_hit[c]) begin
                hold_cnt_nxt[c] = HOLD_CNT_W'(HOLD_UNIT_CYCLES * ({1'b0, hold_pre_r[c]} + {1'b0, hold_post_r[c]}));
            end else if (hold_cnt_r[c] != '0) begin
                hold_cnt_nxt[c] = hold_cnt_r[c] - 1'b1;
            end else begin
                hold_cnt_nxt[c] = '0;
            end
        end
    end

    // Trigger pin synchroniser and edge history
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ext_meta_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_prev_r <= 1'b0;
            timer_prev_r <= '0;
        end else begin
            ext_meta_r <= EXT_TRIG;
            ext_sync_r <= ext_meta_r;
            ext_prev_r <= ext_sync_r;
            timer_prev_r <= TIMER_MATCH;
        end
    end

    // Software-visible configuration
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (!RST_N) begin
                ctrl_drive_r[c] <= 1'b0;
                ctrl_ref_r[c] <= 1'b0;
                code_r[c] <= '0;
                wave_r[c] <= '0;
                hold_post_r[c] <= HOLD_POST_RST;
                hold_pre_r[c] <= HOLD_PRE_RST;
            end else begin
                if (wr_ctrl[c]) begin
                    ctrl_drive_r[c] <= REG_WDATA[CTRL_DRIVE_BIT];
                    ctrl_ref_r[c] <= REG_WDATA[CTRL_REF_BIT];
                end
                if (wr_data[c]) begin
                    code_r[c] <= REG_WDATA[DATA_CODE_LSB +: CODE_W];
                end else if (DMA_WR[c] && wave_r[c].dma_request_enable) begin
                    code_r[c] <= DMA_WDATA[DATA_CODE_LSB +: CODE_W];
                end
                if (wr_wave[c]) begin
                    wave_r[c].offset <= REG_WDATA[WAVE_OFFSET_LSB +: 3];
                    wave_r[c].amplitude_select <= dwt_amp_t'(REG_WDATA[WAVE_AMP_LSB +: 2]);
                    wave_r[c].trigger_source_select <= REG_WDATA[WAVE_TSEL_LSB +: 3];
                    wave_r[c].trigger_function_enable <= REG_WDATA[WAVE_TEN_BIT];
                    wave_r[c].dma_request_enable <= REG_WDATA[WAVE_DMA_BIT];
                    wave_r[c].mode <= dwt_wave_mode_t'(REG_WDATA[WAVE_MODE_LSB +: 2]);
                end
                if (wr_hold[c]) begin
                    // A zero code is kept out so the strobe never collapses
                    if (REG_WDATA[HOLD_POST_LSB +: 4] != 4'h0) begin
                        hold_post_r[c] <= REG_WDATA[HOLD_POST_LSB +: 4];
                    end
                    if (REG_WDATA[HOLD_PRE_LSB +: 4] != 4'h0) begin
                        hold_pre_r[c] <= REG_WDATA[HOLD_PRE_LSB +: 4];
                    end
                end
            end
        end
    end

    // Output buffer and waveform generator
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (!RST_N) begin
                out_code_r[c] <= '0;
                phase_r[c] <= '0;
                tri_r[c] <= '0;
                tri_down_r[c] <= 1'b0;
                lfsr_r[c] <= LFSR_SEED;
            end else if (clr_cmd[c]) begin
                out_code_r[c] <= '0;
                phase_r[c] <= '0;
                tri_r[c] <= '0;
                tri_down_r[c] <= 1'b0;
                lfsr_r[c] <= LFSR_SEED;
            end else if (trig_hit[c]) begin
                out_code_r[c] <= gen_code[c];
                case (wave_r[c].mode)
                    WAVE_SINE: phase_r[c] <= phase_r[c] + 1'b1;
                    WAVE_TRIANGLE: begin
                        if (!tri_down_r[c]) begin
                            if (tri_r[c] >= tri_top[c]) begin
                                tri_down_r[c] <= 1'b1;
                                tri_r[c] <= tri_r[c] - 1'b1;
                            end else begin
                                tri_r[c] <= tri_r[c] + 1'b1;
                            end
                        end else if (tri_r[c] == '0) begin
                            tri_down_r[c] <= 1'b0;
                            tri_r[c] <= tri_r[c] + 1'b1;
                        end else if (tri_r[c] > tri_top[c]) begin
                            tri_r[c] <= tri_top[c];
                        end else begin
                            tri_r[c] <= tri_r[c] - 1'b1;
                        end
                    end
                    WAVE_NOISE: lfsr_r[c] <= {lfsr_r[c][8:0], lfsr_r[c][9] ^ lfsr_r[c][6]};
                    default: phase_r[c] <= phase_r[c];
                endcase
            end
        end
    end

    // Output hold strobe and DMA request
    always_ff @(posedge CORE_CLK) begin
        for (int c = 0; c < NUM_CH; c++) begin
            if (!RST_N) begin
                hold_cnt_r[c] <= '0;
                strobe_r[c] <= 1'b0;
                dma_req_r[c] <= 1'b0;
            end else begin
                hold_cnt_r[c] <= hold_cnt_nxt[c];
                strobe_r[c] <= (hold_cnt_nxt[c] != '0);
                dma_req_r[c] <= trig_hit[c] && wave_r[c].dma_request_enable;
            end
        end
    end

    // Read port: data stand only in the cycle after the strobe
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= '0;
            for (int c = 0; c < NUM_CH; c++) begin
                if (REG_RD && ch_hit[c]) begin
                    case (reg_ofs)
                        OFS_CONV_CONTROL: begin
                            rdata_r[CTRL_DRIVE_BIT] <= ctrl_drive_r[c];
                            rdata_r[CTRL_REF_BIT] <= ctrl_ref_r[c];
                        end
                        OFS_CONV_DATA: rdata_r[DATA_CODE_LSB +: CODE_W] <= code_r[c];
                        OFS_WAVE_CONTROL: begin
                            rdata_r[WAVE_OFFSET_LSB +: 3] <= wave_r[c].offset;
                            rdata_r[WAVE_AMP_LSB +: 2] <= wave_r[c].amplitude_select;
                            rdata_r[WAVE_TSEL_LSB +: 3] <= wave_r[c].trigger_source_select;
                            rdata_r[WAVE_TEN_BIT] <= wave_r[c].trigger_function_enable;
                            rdata_r[WAVE_DMA_BIT] <= wave_r[c].dma_request_enable;
                            rdata_r[WAVE_MODE_LSB +: 2] <= wave_r[c].mode;
                        end
                        OFS_HOLD_TIME_ADJUST: begin
                            rdata_r[HOLD_POST_LSB +: 4] <= hold_post_r[c];
                            rdata_r[HOLD_PRE_LSB +: 4] <= hold_pre_r[c];
                        end
                        default: rdata_r <= '0;
                    endcase
                end
            end
        end
    end

    assign REG_RDATA = rdata_r;
    assign DMA_REQ = dma_req_r;

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            ANALOG[c].analog_drive_enable = ctrl_drive_r[c];
            ANALOG[c].reference_connect = ctrl_ref_r[c];
            ANALOG[c].output_hold_strobe = strobe_r[c];
            ANALOG[c].code = out_code_r[c];
        end
    end
endmodule

// ### verification/dwt_asserts.sv
// Concurrent checks on the converter control block ports, channel 0
module dwt_asserts (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [dwt_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [dwt_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [dwt_pkg::DATA_W-1:0] REG_RDATA,
    input wire logic [dwt_pkg::NUM_CH-1:0] DMA_REQ,
    input wire logic [dwt_pkg::NUM_TIMERS-1:0] TIMER_MATCH,
    input wire dwt_pkg::dwt_analog_t [dwt_pkg::NUM_CH-1:0] ANALOG
);
    import dwt_pkg::*;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    logic ten_r;
    logic dma_r;
    logic [2:0] tsel_r;
    logic clr_wr;
    logic sw_wr;
    assign clr_wr = REG_WR && REG_ADDR == 16'h000c && REG_WDATA[15];
    assign sw_wr = REG_WR && REG_ADDR == 16'h000c && REG_WDATA[0] && !REG_WDATA[15];
    // Shadow of the trigger settings of channel 0
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ten_r <= 1'b0;
            dma_r <= 1'b0;
            tsel_r <= 3'h0;
        end else if (REG_WR && REG_ADDR == 16'h0008) begin
            ten_r <= REG_WDATA[8];
            dma_r <= REG_WDATA[7];
            tsel_r <= REG_WDATA[11:9];
        end
    end
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
        else $error("read data not zero outside its slot");
    a_ctrl_follow: assert property (REG_WR && REG_ADDR == 16'h0000 |=>
        ANALOG[0].analog_drive_enable == $past(REG_WDATA[0]) && ANALOG[0].reference_connect == $past(REG_WDATA[1]))
        else $error("control bits not applied to analog side");
    a_ctrl_read: assert property (REG_RD && REG_ADDR == 16'h0000 |=>
        REG_RDATA == {30'h0, ANALOG[0].reference_connect, ANALOG[0].analog_drive_enable})
        else $error("control read differs from applied bits");
    a_code_cause: assert property ($changed(ANALOG[0].code) |->
        ANALOG[0].output_hold_strobe || $past(clr_wr))
        else $error("code moved without trigger or clear");
    a_trig_gate: assert property ((DMA_REQ[0] || $rose(ANALOG[0].output_hold_strobe)) |-> $past(ten_r))
        else $error("update while triggers disabled");
    a_dma_gate: assert property (DMA_REQ[0] |-> $past(dma_r))
        else $error("dma request while dma disabled");
    a_sw_fire: assert property (sw_wr && ten_r && tsel_r == 3'h0 |=>
        ANALOG[0].output_hold_strobe && DMA_REQ[0] == $past(dma_r))
        else $error("software trigger not served");
    a_timer_fire: assert property ($rose(TIMER_MATCH[0]) && ten_r && tsel_r == 3'h2 |=>
        ANALOG[0].output_hold_strobe)
        else $error("timer event not served");
    c_sw: cover property (sw_wr && ten_r && tsel_r == 3'h0);
    c_dma: cover property (DMA_REQ[0]);
    c_timer: cover property ($rose(TIMER_MATCH[0]) && ten_r && tsel_r == 3'h2);
endmodule

bind dwt_top dwt_asserts i_asserts (.CORE_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
    .DMA_REQ, .TIMER_MATCH, .ANALOG);

// ### verification/dwt_conv_model.sv
// Behavioural model of one converter core and its analog output pin
module dwt_conv_model (
    input wire dwt_pkg::dwt_analog_t ana,
    output wire logic [9:0] pin_level
);
    import dwt_pkg::*;
    // Stopped core floats the pin; without reference the pin sits near ground
    assign pin_level = !ana.analog_drive_enable ? 10'hzzz : (ana.reference_connect ? ana.code : 10'h000);
endmodule

// ### verification/testbench.sv
// Self-checking bench for the two-channel converter control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dwt_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [NUM_CH-1:0] dma_wr = '0;
    logic [DATA_W-1:0] dma_wdata = '0;
    logic [NUM_CH-1:0] dma_req;
    logic ext_trig = 1'b0;
    logic [NUM_TIMERS-1:0] tmatch = '0;
    dwt_analog_t [NUM_CH-1:0] ana;
    wire logic [9:0] pin0;
    int n_fail = 0;
    int n_checks = 0;
    int cnt;
    always #20 clk = ~clk;
    dwt_top i_dut (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(rdata), .DMA_WR(dma_wr), .DMA_WDATA(dma_wdata), .DMA_REQ(dma_req),
        .EXT_TRIG(ext_trig), .TIMER_MATCH(tmatch), .ANALOG(ana));
    dwt_conv_model i_core0 (.ana(ana[0]), .pin_level(pin0));
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] exp, string what);
        @(posedge clk);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask
    task automatic dma(logic [1:0] m, logic [31:0] d);
        @(posedge clk);
        dma_wdata <= d;
        dma_wr <= m;
        @(posedge clk);
        dma_wr <= 2'b00;
    endtask
    task automatic wait_code(logic [9:0] e, string what);
        for (int i = 0; i < 10 && ana[0].code !== e; i++) begin
            @(posedge clk);
            #1;
        end
        chk(what, e, ana[0].code);
        if (ana[0].code !== e) begin
            close_out();
        end
    endtask
    // Clear, then run one period plus one step of software triggers
    task automatic gen(logic [31:0] cfg, int n, int lo, int hi, string w);
        logic [9:0] first;
        logic [9:0] mn;
        logic [9:0] mx;
        logic [9:0] l;
        l = LFSR_SEED;
        mn = 10'h3ff;
        mx = 10'h000;
        wr(16'h000c, 32'h8000);
        wr(16'h0008, cfg);
        #1 chk("clear", 0, ana[0].code);
        for (int i = 0; i <= n; i++) begin
            wr(16'h000c, 32'h1);
            #1;
            if (i == 0) first = ana[0].code;
            if (i < n && ana[0].code < mn) mn = ana[0].code;
            if (i < n && ana[0].code > mx) mx = ana[0].code;
            if (cfg[1:0] == 2'b10) begin
                chk("noise_seq", l, ana[0].code);
                l = {l[8:0], l[9] ^ l[6]};
            end
        end
        chk({w, "_period"}, first, ana[0].code);
        chk({w, "_min"}, lo, mn);
        chk({w, "_max"}, hi, mx);
        $display("test %s done", w);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("BAD watchdog exp finish got hang");
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(16'h0010, 32'h81, "hold_rst");
        rd(16'h1010, 32'h81, "hold_rst_ch1");
        rd(16'h0008, 32'h0, "wave_rst");
        rd(16'h000c, 32'h0, "cmd_read");
        rd(16'h0100, 32'h0, "unmapped");
        chk("pin_hiz", 1, pin0 === 10'hzzz);
        wr(16'h1000, 32'h2);
        #1 chk("ch1_ref", 2'b10, {ana[1].reference_connect, ana[0].reference_connect});
        $display("test reset done");
        wr(16'h0004, 32'hffff_ffff);
        rd(16'h0004, 32'h0000_ffc0, "data_mask");
        rd(16'h1004, 32'h0, "data_ch1");
        wr(16'h0008, 32'hfffa_ffff);
        rd(16'h0008, 32'h001a_0f83, "wave_fields");
        wr(16'h0010, 32'hf5);
        wr(16'h0010, 32'h03);
        rd(16'h0010, 32'hf3, "hold_post_zero");
        wr(16'h0010, 32'h30);
        rd(16'h0010, 32'h33, "hold_pre_zero");
        $display("test fields done");
        wr(16'h0008, 32'h0);
        wr(16'h0004, 32'h0000_5540);
        wr(16'h0000, 32'h3);
        wr(16'h000c, 32'h8000);
        wr(16'h0010, 32'h81);
        wr(16'h000c, 32'h1);
        #1 chk("trig_off", 0, ana[0].code);
        wr(16'h0008, 32'h180);
        wr(16'h000c, 32'h1);
        #1 chk("sw_code", 10'h155, ana[0].code);
        chk("dma_req", 1, dma_req[0]);
        chk("pin_code", 10'h155, pin0);
        chk("ch1_code", 0, ana[1].code);
        chk("ch1_dma", 0, dma_req[1]);
        chk("ch1_strobe", 0, ana[1].output_hold_strobe);
        cnt = 0;
        while (ana[0].output_hold_strobe === 1'b1 && cnt < 100) begin
            cnt++;
            @(posedge clk);
            #1;
        end
        chk("strobe_len", 18, cnt);
        if (cnt >= 100) begin
            close_out();
        end
        wr(16'h0004, 32'h0000_aa80);
        wr(16'h000c, 32'h0);
        #1 chk("cmd_zero", 10'h155, ana[0].code);
        $display("test software trigger done");
        wr(16'h0008, 32'h300);
        @(posedge clk);
        ext_trig <= 1'b1;
        wait_code(10'h2aa, "ext_code");
        @(posedge clk);
        ext_trig <= 1'b0;
        for (int k = 0; k < 6; k++) begin
            wr(16'h0008, 32'h100 | ((k + 2) << 9));
            wr(16'h0004, (k + 1) << 6);
            @(posedge clk);
            tmatch <= 6'h01 << ((k + 1) % 6);
            @(posedge clk);
            tmatch <= '0;
            #1 chk("timer_other", (k == 0) ? 32'h2aa : k, ana[0].code);
            @(posedge clk);
            tmatch <= 6'h01 << k;
            @(posedge clk);
            tmatch <= '0;
            #1 chk("timer_hit", k + 1, ana[0].code);
        end
        $display("test trigger sources done");
        wr(16'h0008, 32'h180);
        dma(2'b01, 32'h0000_ffc0);
        rd(16'h0004, 32'h0000_ffc0, "dma_load");
        rd(16'h1004, 32'h0, "dma_ch1");
        wr(16'h0008, 32'h100);
        dma(2'b01, 32'h0000_0040);
        rd(16'h0004, 32'h0000_ffc0, "dma_off");
        $display("test dma done");
        gen(32'h0000_0101, 2046, 0, 1023, "tri_full");
        gen(32'h0005_0101, 1022, 128, 639, "tri_half");
        gen(32'h000a_0101, 510, 256, 511, "tri_quarter");
        gen(32'h001f_0101, 510, 768, 1023, "tri_reserved");
        gen(32'h0000_0103, 2048, 1, 1023, "sine");
        gen(32'h0000_0102, 1023, 1, 1023, "noise");
        close_out();
    end
endmodule
